// ### rtl/comparator_pkg.sv
// Package: register map, field layout and types of the comparator control logic
package comparator_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] REG_CTRL_ADDR       = 8'h18;
  localparam logic [7:0] REG_SEL_ADDR        = 8'h19;
  localparam logic [7:0] REG_IRQ_STATUS_ADDR = 8'h3A;
  localparam logic [7:0] REG_IRQ_ENABLE_ADDR = 8'h3B;
  localparam logic [7:0] REG_IRQ_CLEAR_ADDR  = 8'h3C;
  localparam logic [7:0] REG_T2_CLKSEL_ADDR  = 8'h3D;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_ENABLE_BIT  = 7;
  localparam int CTRL_RESULT_BIT  = 6;
  localparam int CTRL_SAMPLE_BIT  = 5;
  localparam int CTRL_INVERT_BIT  = 4;
  localparam int CTRL_MINUS_LSB   = 1;
  localparam int CTRL_PLUS_BIT    = 0;
  localparam int SEL_OUT_EN_BIT   = 7;
  localparam int SEL_WAKE_EN_BIT  = 6;
  localparam int SEL_HIGH_BIT     = 5;
  localparam int SEL_LOW_BIT      = 4;
  localparam int SEL_LEVEL_LSB    = 0;
  localparam int IRQ_RISE_BIT     = 0;
  localparam int IRQ_FALL_BIT     = 1;
  localparam int IRQ_WAKE_BIT     = 2;
  localparam int IRQ_COUNT        = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and codes
  localparam logic [7:0]           CTRL_RESET       = 8'h00;
  localparam logic [7:0]           SEL_RESET        = 8'h00;
  localparam logic [3:0]           T2_CLKSEL_RESET  = 4'h0;
  localparam logic [IRQ_COUNT-1:0] IRQ_RESET        = 3'h0;
  localparam logic [3:0]           T2_CLK_FROM_CMP  = 4'h5;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    MINUS_PA3      = 3'h0,
    MINUS_PA4      = 3'h1,
    MINUS_BANDGAP  = 3'h2,
    MINUS_LADDER   = 3'h3,
    MINUS_PB6      = 3'h4,
    MINUS_PB7      = 3'h5,
    MINUS_RSVD6    = 3'h6,
    MINUS_RSVD7    = 3'h7
  } minus_sel_t;

  typedef struct packed {
    logic       enable;
    logic       result;
    logic       sample;
    logic       invert;
    minus_sel_t minus_sel;
    logic       plus_pin4;
  } ctrl_t;

  typedef struct packed {
    logic       out_en;
    logic       wake_en;
    logic       range_high;
    logic       range_low;
    logic [3:0] level;
  } sel_t;

endpackage : comparator_pkg

// ### rtl/comparator_sync.sv
// Two-stage synchroniser for the comparator output and the timer2 sampling clock
`timescale 1ns/1ps

module comparator_sync (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);

  logic [1:0] stage1_reg;
  logic [1:0] stage2_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stage1_reg <= 2'h0;
      stage2_reg <= 2'h0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule // comparator_sync

// ### rtl/comparator_control_logic.sv
// Digital control and result path around the analog comparator
`timescale 1ns/1ps

module comparator_control_logic (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Analog core
  input  wire logic       cmp_raw,
  input  wire logic       timer2_sample_clock,
  output logic            cmp_enable,
  output logic      [2:0] minus_select,
  output logic            minus_connect,
  output logic            plus_pin4,
  output logic            ladder_high,
  output logic            ladder_low,
  output logic      [3:0] ladder_level,
  // Pin and system
  output logic            port_a_pin0_o,
  output logic            port_a_pin0_oe,
  output logic            wake_event,
  output logic            timer2_cmp_clock,
  output logic            irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  comparator_pkg::ctrl_t                     ctrl_reg;
  comparator_pkg::sel_t                      sel_reg;
  logic [3:0]                                t2_clksel_reg;
  logic [comparator_pkg::IRQ_COUNT-1:0]      irq_status_reg;
  logic [comparator_pkg::IRQ_COUNT-1:0]      irq_enable_reg;
  logic [comparator_pkg::IRQ_COUNT-1:0]      irq_event;
  logic [1:0]                                sync_q;
  logic                                      tm2_d_reg;
  logic                                      tm2_rise;
  logic                                      result_reg;
  logic                                      result_d_reg;
  logic                                      result_pol;
  logic                                      result_out_reg;
  logic                                      minus_connect_reg;
  logic                                      pin0_o_reg;
  logic                                      pin0_oe_reg;
  logic                                      wake_reg;
  logic                                      t2_clk_reg;
  logic                                      irq_reg;
  logic [7:0]                                rdata_reg;
  logic [7:0]                                rdata_next;

  // Reserved minus-input codes
  function automatic logic is_reserved(input comparator_pkg::minus_sel_t code);
    is_reserved = (code == comparator_pkg::MINUS_RSVD6) ||
                  (code == comparator_pkg::MINUS_RSVD7);
  endfunction

  // Address match helper
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes
  // enable bit written
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_reg <= comparator_pkg::ctrl_t'(comparator_pkg::CTRL_RESET);
    end else if (reg_wr && hit(reg_addr, comparator_pkg::REG_CTRL_ADDR)) begin
      ctrl_reg        <= comparator_pkg::ctrl_t'(reg_wdata);
      ctrl_reg.result <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sel_reg <= comparator_pkg::sel_t'(comparator_pkg::SEL_RESET);
    end else if (reg_wr && hit(reg_addr, comparator_pkg::REG_SEL_ADDR)) begin
      sel_reg <= comparator_pkg::sel_t'(reg_wdata);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      t2_clksel_reg  <= comparator_pkg::T2_CLKSEL_RESET;
      irq_enable_reg <= comparator_pkg::IRQ_RESET;
    end else if (reg_wr) begin
      if (hit(reg_addr, comparator_pkg::REG_T2_CLKSEL_ADDR)) begin
        t2_clksel_reg <= reg_wdata[3:0];
      end
      if (hit(reg_addr, comparator_pkg::REG_IRQ_ENABLE_ADDR)) begin
        irq_enable_reg <= reg_wdata[comparator_pkg::IRQ_COUNT-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  // two-stage sync
  comparator_sync u_sync (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .async_in ({timer2_sample_clock, cmp_raw}),
    .sync_out (sync_q)
  );

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tm2_d_reg <= 1'b0;
    end else begin
      tm2_d_reg <= sync_q[1];
    end
  end

  assign tm2_rise = sync_q[1] & ~tm2_d_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Result path
  // reserved code forces zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      result_reg   <= 1'b0;
      result_d_reg <= 1'b0;
    end else begin
      result_reg   <= ctrl_reg.enable && !is_reserved(ctrl_reg.minus_sel) && sync_q[0];
      result_d_reg <= result_reg;
    end
  end

  assign result_pol = result_reg ^ ctrl_reg.invert;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      result_out_reg <= 1'b0;
    end else if (!ctrl_reg.sample || tm2_rise) begin
      result_out_reg <= result_pol;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin0_o_reg  <= 1'b0;
      pin0_oe_reg <= 1'b0;
    end else begin
      pin0_o_reg  <= sel_reg.out_en & result_out_reg;
      pin0_oe_reg <= sel_reg.out_en;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= sel_reg.wake_en && (result_reg != result_d_reg);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      t2_clk_reg <= 1'b0;
    end else begin
      t2_clk_reg <= (t2_clksel_reg == comparator_pkg::T2_CLK_FROM_CMP) & result_out_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      minus_connect_reg <= 1'b0;
    end else begin
      minus_connect_reg <= !is_reserved(ctrl_reg.minus_sel);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status
  assign irq_event[comparator_pkg::IRQ_RISE_BIT] = result_reg & ~result_d_reg;
  assign irq_event[comparator_pkg::IRQ_FALL_BIT] = ~result_reg & result_d_reg;
  assign irq_event[comparator_pkg::IRQ_WAKE_BIT] = wake_reg;

  generate
    for (genvar i = 0; i < comparator_pkg::IRQ_COUNT; i++) begin : g_irq
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          irq_status_reg[i] <= 1'b0;
        end else if (irq_event[i]) begin
          irq_status_reg[i] <= 1'b1;
        end else if (reg_wr && hit(reg_addr, comparator_pkg::REG_IRQ_CLEAR_ADDR) &&
                     reg_wdata[i]) begin
          irq_status_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_reg & irq_enable_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb begin
    rdata_next = 8'h00;
    case (reg_addr)
      comparator_pkg::REG_CTRL_ADDR: begin
        rdata_next = ctrl_reg;
        rdata_next[comparator_pkg::CTRL_RESULT_BIT] = result_reg;
      end
      comparator_pkg::REG_SEL_ADDR:        rdata_next = sel_reg;
      comparator_pkg::REG_IRQ_STATUS_ADDR: rdata_next = {5'h00, irq_status_reg};
      comparator_pkg::REG_IRQ_ENABLE_ADDR: rdata_next = {5'h00, irq_enable_reg};
      comparator_pkg::REG_T2_CLKSEL_ADDR:  rdata_next = {4'h0, t2_clksel_reg};
      default:                             rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  // plus input route
  assign plus_pin4        = ctrl_reg.plus_pin4;
  assign cmp_enable       = ctrl_reg.enable;
  assign minus_select     = ctrl_reg.minus_sel;
  assign minus_connect    = minus_connect_reg;
  assign ladder_high      = sel_reg.range_high;
  assign ladder_low       = sel_reg.range_low;
  assign ladder_level     = sel_reg.level;
  assign port_a_pin0_o    = pin0_o_reg;
  assign port_a_pin0_oe   = pin0_oe_reg;
  assign wake_event       = wake_reg;
  assign timer2_cmp_clock = t2_clk_reg;
  assign irq              = irq_reg;
  assign reg_rdata        = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_enable_write;
    reg_wr && reg_addr == comparator_pkg::REG_CTRL_ADDR |=> cmp_enable == $past(reg_wdata[7]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("Enable bit not taken from write");

  property p_result_read;
    reg_rd && reg_addr == comparator_pkg::REG_CTRL_ADDR |=> reg_rdata[6] == $past(result_reg);
  endproperty
  a_result_read: assert property (p_result_read)
    else $error("Result bit readback wrong");

  property p_sample_hold;
    ctrl_reg.sample && !tm2_rise |=> $stable(result_out_reg);
  endproperty
  a_sample_hold: assert property (p_sample_hold)
    else $error("Sampled output changed without timer2 edge");

  property p_polarity;
    !ctrl_reg.sample |=> result_out_reg == ($past(result_reg) ^ $past(ctrl_reg.invert));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("Output polarity wrong");

  property p_reserved_zero;
    result_reg |-> $past(ctrl_reg.enable) && !is_reserved($past(ctrl_reg.minus_sel));
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Result high while disabled or reserved");

  property p_pin0_drive;
    port_a_pin0_o |-> port_a_pin0_oe && $past(result_out_reg);
  endproperty
  a_pin0_drive: assert property (p_pin0_drive)
    else $error("Pin driven without enable");

  property p_wake;
    wake_event == ($past(sel_reg.wake_en) && ($past(result_reg) != $past(result_reg, 2)));
  endproperty
  a_wake: assert property (p_wake)
    else $error("Wake event does not match result change");

  property p_t2_clock;
    timer2_cmp_clock |-> $past(t2_clksel_reg) == comparator_pkg::T2_CLK_FROM_CMP;
  endproperty
  a_t2_clock: assert property (p_t2_clock)
    else $error("Timer2 clock from comparator without select code");

  property p_level_write;
    reg_wr && reg_addr == comparator_pkg::REG_SEL_ADDR
      |=> ladder_level == $past(reg_wdata[3:0]) && ladder_high == $past(reg_wdata[5]);
  endproperty
  a_level_write: assert property (p_level_write)
    else $error("Ladder setting not taken from write");

  property p_sync_delay;
    ctrl_reg.enable && !is_reserved(ctrl_reg.minus_sel) && $stable(ctrl_reg) [*3]
      |-> result_reg == $past(cmp_raw, 3);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("Result not three cycles behind raw input");

  c_wake:     cover property (wake_event);
  c_irq:      cover property (irq);
  c_sampled:  cover property (ctrl_reg.sample && tm2_rise ##1 result_out_reg);
  c_reserved: cover property (ctrl_reg.enable && is_reserved(ctrl_reg.minus_sel));

endmodule // comparator_control_logic

// ### verif/comparator_analog_model.sv
// Behavioural model of the analog comparator core, reference ladder and pins
`timescale 1ns/1ps

module comparator_analog_model #(
  parameter int BANDGAP_MV   = 1200,
  parameter int LOW_BASE_MV  = 0,
  parameter int MID_BASE_MV  = 800,
  parameter int HIGH_BASE_MV = 1600,
  parameter int STEP_MV      = 50
) (
  // Controls from the block
  input  wire logic        cmp_enable,
  input  wire logic [2:0]  minus_select,
  input  wire logic        minus_connect,
  input  wire logic        plus_pin4,
  input  wire logic        ladder_high,
  input  wire logic        ladder_low,
  input  wire logic [3:0]  ladder_level,
  // Pin voltages in millivolts
  input  wire logic [11:0] v_pa3,
  input  wire logic [11:0] v_pa4,
  input  wire logic [11:0] v_pb6,
  input  wire logic [11:0] v_pb7,
  // Comparator output
  output logic             cmp_raw
);
  int ladder_mv;
  int minus_mv;
  int plus_mv;

  always_comb begin
    ladder_mv = (ladder_high ? HIGH_BASE_MV : (ladder_low ? LOW_BASE_MV : MID_BASE_MV))
                + int'(ladder_level) * STEP_MV;
    case (minus_select)
      3'h0: minus_mv = int'(v_pa3);
      3'h1: minus_mv = int'(v_pa4);
      3'h2: minus_mv = BANDGAP_MV;
      3'h3: minus_mv = ladder_mv;
      3'h4: minus_mv = int'(v_pb6);
      3'h5: minus_mv = int'(v_pb7);
      default: minus_mv = 0;
    endcase
    plus_mv = plus_pin4 ? int'(v_pa4) : ladder_mv;
    // idle or unconnected core gives low
    cmp_raw = cmp_enable && minus_connect && (plus_mv > minus_mv);
  end
endmodule // comparator_analog_model

// ### verif/test_comparator_control_logic.sv
// Self-checking testbench of the comparator control logic
`timescale 1ns/1ps

module test_comparator_control_logic;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        cmp_raw;
  logic        timer2_sample_clock = 1'b0;
  logic        cmp_enable, minus_connect, plus_pin4, ladder_high, ladder_low;
  logic [2:0]  minus_select;
  logic [3:0]  ladder_level;
  logic        port_a_pin0_o, port_a_pin0_oe, wake_event, timer2_cmp_clock, irq;
  logic [11:0] v_pa3 = 12'hBB8, v_pa4 = 12'hBB8, v_pb6 = 12'hBB8, v_pb7 = 12'hBB8;
  int          miscompares = 0;
  int          n_compared = 0;

  always #5 clk_sys = ~clk_sys;

  comparator_control_logic comparator_control_logic_i (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_raw(cmp_raw),
    .timer2_sample_clock(timer2_sample_clock), .cmp_enable(cmp_enable),
    .minus_select(minus_select), .minus_connect(minus_connect), .plus_pin4(plus_pin4),
    .ladder_high(ladder_high), .ladder_low(ladder_low), .ladder_level(ladder_level),
    .port_a_pin0_o(port_a_pin0_o), .port_a_pin0_oe(port_a_pin0_oe),
    .wake_event(wake_event), .timer2_cmp_clock(timer2_cmp_clock), .irq(irq));

  comparator_analog_model comparator_analog_model_i (
    .cmp_enable(cmp_enable), .minus_select(minus_select), .minus_connect(minus_connect),
    .plus_pin4(plus_pin4), .ladder_high(ladder_high), .ladder_low(ladder_low),
    .ladder_level(ladder_level), .v_pa3(v_pa3), .v_pa4(v_pa4), .v_pb6(v_pb6),
    .v_pb7(v_pb7), .cmp_raw(cmp_raw));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp, what);
  endtask

  task automatic settle();
    repeat (8) @(posedge clk_sys);
    #1;
  endtask

  task automatic t2_pulse();
    @(posedge clk_sys);
    timer2_sample_clock <= 1'b1;
    repeat (3) @(posedge clk_sys);
    timer2_sample_clock <= 1'b0;
    settle();
  endtask

  task automatic count_wake(input int exp_n);
    int n;
    n = 0;
    repeat (12) begin
      @(posedge clk_sys);
      #1;
      if (wake_event === 1'b1) n++;
    end
    chk(8'(n), 8'(exp_n), "wake pulses");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic sc_reset();
    logic [7:0] addrs [7] = '{8'h18, 8'h19, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h55};
    foreach (addrs[i]) rd_chk(addrs[i], 8'h00, "reset or unmapped read");
    chk({5'h00, cmp_enable, port_a_pin0_oe, irq}, 8'h00, "outputs after reset");
  endtask

  task automatic sc_fields();
    wr(8'h18, 8'h7F);
    rd_chk(8'h18, 8'h3F, "ctrl readback");
    @(posedge clk_sys);
    #1;
    chk(reg_rdata, 8'h00, "read data one cycle only");
    chk({4'h0, cmp_enable, minus_select}, 8'h07, "ctrl outputs");
    chk({7'h00, minus_connect}, 8'h00, "reserved code");
    wr(8'h55, 8'hFF);
    wr(8'h19, 8'hBA);
    rd_chk(8'h19, 8'hBA, "sel readback");
    chk({ladder_high, ladder_low, 2'h0, ladder_level}, 8'hCA, "ladder");
    chk({7'h00, port_a_pin0_oe}, 8'h01, "pin drive");
  endtask

  task automatic sc_mux();
    logic [7:0] ctrl;
    wr(8'h19, 8'h8E);
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_sys);
      v_pa3 <= (c == 0) ? 12'h064 : 12'hBB8;
      v_pa4 <= (c == 1) ? 12'h064 : 12'hBB8;
      v_pb6 <= (c == 4) ? 12'h064 : 12'hBB8;
      v_pb7 <= (c == 5) ? 12'h064 : 12'hBB8;
      ctrl = 8'h80 | 8'(c << 1);
      wr(8'h18, ctrl);
      settle();
      rd_chk(8'h18, ctrl | ((c != 3 && c < 6) ? 8'h40 : 8'h00), "minus mux");
      chk({6'h00, plus_pin4, minus_connect}, (c < 6) ? 8'h01 : 8'h00, "connect");
    end
  endtask

  task automatic sc_plus_pin();
    wr(8'h18, 8'h85);
    @(posedge clk_sys);
    v_pa4 <= 12'h7D0;
    settle();
    rd_chk(8'h18, 8'hC5, "plus pin high");
    chk({7'h00, plus_pin4}, 8'h01, "plus route");
    chk({7'h00, port_a_pin0_o}, 8'h01, "pin natural");
    wr(8'h18, 8'h95);
    settle();
    chk({7'h00, port_a_pin0_o}, 8'h00, "pin inverted");
    rd_chk(8'h18, 8'hD5, "result not inverted");
    @(posedge clk_sys);
    v_pa4 <= 12'h1F4;
    settle();
    rd_chk(8'h18, 8'h95, "plus pin low");
  endtask

  task automatic sc_sampled();
    wr(8'h18, 8'h85);
    wr(8'h18, 8'hA5);
    wr(8'h3D, 8'h05);
    @(posedge clk_sys);
    v_pa4 <= 12'h7D0;
    settle();
    chk({7'h00, port_a_pin0_o}, 8'h00, "held until sample");
    chk({7'h00, timer2_cmp_clock}, 8'h00, "t2 clock held");
    t2_pulse();
    chk({7'h00, port_a_pin0_o}, 8'h01, "sampled result");
    chk({7'h00, timer2_cmp_clock}, 8'h01, "t2 clock source");
    wr(8'h3D, 8'h04);
    settle();
    chk({7'h00, timer2_cmp_clock}, 8'h00, "t2 other source");
  endtask

  task automatic sc_wake_irq();
    wr(8'h18, 8'h85);
    wr(8'h19, 8'hCE);
    wr(8'h3C, 8'h07);
    wr(8'h3B, 8'h05);
    settle();
    rd_chk(8'h3A, 8'h00, "status cleared");
    @(posedge clk_sys);
    v_pa4 <= 12'h1F4;
    count_wake(1);
    rd_chk(8'h3A, 8'h06, "fall and wake");
    chk({7'h00, irq}, 8'h01, "irq on wake");
    wr(8'h3B, 8'h00);
    settle();
    chk({7'h00, irq}, 8'h00, "irq masked");
    wr(8'h3B, 8'h02);
    wr(8'h3C, 8'h04);
    settle();
    chk({7'h00, irq}, 8'h01, "irq on fall");
    wr(8'h3C, 8'h02);
    settle();
    chk({7'h00, irq}, 8'h00, "irq cleared");
    wr(8'h19, 8'h8E);
    @(posedge clk_sys);
    v_pa4 <= 12'h7D0;
    count_wake(0);
    rd_chk(8'h3A, 8'h01, "rise only");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    sc_reset();
    sc_fields();
    sc_mux();
    sc_plus_pin();
    sc_sampled();
    sc_wake_irq();
    close_out();
  end

  initial begin
    #200000;
    miscompares++;
    close_out();
  end
endmodule // test_comparator_control_logic
